// ===== mats_pkg.sv
// Package for the analog, timer and trim control register bank.
// Assumes an 8-bit register port driven by the core on one clock.
package mats_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_ADC_HIGH_REFERENCE_CTRL = 8'h13;
  localparam logic [7:0] ADDR_ADC_SAMPLE_RESOLUTION_CTRL = 8'h14;
  localparam logic [7:0] ADDR_PORT_A_WAKEUP_ENABLE = 8'h15;
  localparam logic [7:0] ADDR_ANALOG_PIN_ONLY_SELECT = 8'h16;
  localparam logic [7:0] ADDR_EXT_INTERRUPT_EDGE_CTRL = 8'h18;
  localparam logic [7:0] ADDR_TIMER_PWM_UPPER_BITS = 8'h19;
  localparam logic [7:0] ADDR_ANALOG_CIRCUIT_ENABLE = 8'h1A;
  localparam logic [7:0] ADDR_RES_FREQ_CONV_CTRL = 8'h1B;
  localparam logic [7:0] ADDR_TIMER3_PWM3_UPPER_BITS = 8'h1C;
  localparam logic [7:0] ADDR_OSC_TRIM_HIGH = 8'h1D;
  localparam logic [7:0] ADDR_OSC_TRIM_LOW = 8'h1E;

  // Reset values
  localparam logic RST_EXT_REF_SELECT = 1'b0;
  localparam logic [1:0] RST_INT_REF_LEVEL = 2'h3;
  localparam logic [1:0] RST_SAMPLE_PULSE_WIDTH = 2'h2;
  localparam logic [1:0] RST_CONVERSION_RESOLUTION = 2'h2;
  localparam logic [7:0] RST_PORT_A_WAKE_ENABLE = 8'hFF;
  localparam logic [7:0] RST_ANALOG_PIN_ONLY = 8'h00;
  localparam logic [7:0] RST_EXT_INTERRUPT_EDGE = 8'h05;
  localparam logic [3:0] RST_OSC_TRIM_LOW_NIBBLE = 4'h8;

  // Field codes
  localparam logic [1:0] EDGE_RESERVED = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] LVL_2V = 2'h0;
  localparam logic [1:0] LVL_3V = 2'h1;
  localparam logic [1:0] LVL_4V = 2'h2;
  localparam logic [1:0] LVL_VDD = 2'h3;
  localparam logic [3:0] PAD_LAST_CODE = 4'hD;
  localparam logic [3:0] PAD_PORT_B_BASE = 4'h8;

  // ADC clock dividers, codes 00..11
  localparam logic [4:0] DIV_CODE0 = 5'h10;
  localparam logic [4:0] DIV_CODE1 = 5'h08;
  localparam logic [4:0] DIV_CODE2 = 5'h01;
  localparam logic [4:0] DIV_CODE3 = 5'h02;

  // Sampling FSM
  typedef enum logic [1:0] {
    MATS_SMP_IDLE = 2'b00,
    MATS_SMP_RUN = 2'b01,
    MATS_SMP_DONE = 2'b11
  } mats_smp_t;

endpackage : mats_pkg

// ===== mats_regs.sv
// Analog, timer-upper-bit and oscillator-trim control register bank.
// Assumes a core register port with read data one cycle after the strobe.
//
// What this block does
// (R1) Reference bit picks internal level or pin
// (R2) Level code: 2V, 3V, 4V, supply
// (R3) Sample pulse 1,2,4,8 ADC clocks
// (R4) Resolution 8, 10, else 12 bits
// (R5) Port B analog-only bits make pure analog
// (R6) Port A analog-only bits, reset zero
// (R7) Port A wake enables, reset all ones
// (R8) Irq pin selects route port B pins
// (R9) Edge codes rising, falling, both
// (R10) Top two edge bits plain storage
// (R11) Timer2 upper: write reload, read live
// (R12) Timer1 upper: write reload, read live
// (R13) Timer3 upper: write reload, read live
// (R14) PWM2 and PWM1 duty upper bits
// (R15) PWM3 duty upper bits at Timer3 byte
// (R16) Comparator enable bit, reset zero
// (R17) Resistance-to-frequency enable, reset zero
// (R18) Pad select: port A 0-7, B 0-5
// (R19) Trim loads factory bits; slow mode writes
// (R20) ADC clock is CPU clock divided
// (R21) Reserved edge code gives no trigger
`timescale 1ns/1ps
module mats_regs (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Factory trim and mode
  input wire logic [6:0] factory_trim_i,
  input wire logic slow_mode_i,
  // Live timer counters
  input wire logic [9:0] timer1_count_i,
  input wire logic [9:0] timer2_count_i,
  input wire logic [9:0] timer3_count_i,
  // Sampling request and ADC clock select
  input wire logic sample_start_i,
  input wire logic [1:0] adc_clock_divider_i,
  output logic sample_pulse_o,
  // External interrupt pins
  input wire logic pb0_i,
  input wire logic pb1_i,
  output logic ext_irq0_trig_o,
  output logic ext_irq1_trig_o,
  // ADC reference and resolution
  output logic ext_ref_select_o,
  output logic [1:0] int_ref_level_o,
  output logic [1:0] conversion_resolution_o,
  output logic res12_o,
  // Pin modes
  output logic [4:0] port_a_analog_only_o,
  output logic [5:0] port_b_analog_only_o,
  output logic [7:0] port_a_wake_enable_o,
  output logic ext_irq0_pin_select_o,
  output logic ext_irq1_pin_select_o,
  output logic [1:0] ext_irq0_edge_o,
  output logic [1:0] ext_irq1_edge_o,
  // Timer reload and PWM duty upper bits
  output logic [1:0] timer1_upper_bits_o,
  output logic [1:0] timer2_upper_bits_o,
  output logic [1:0] timer3_upper_bits_o,
  output logic timer1_upper_load_o,
  output logic timer2_upper_load_o,
  output logic timer3_upper_load_o,
  output logic [1:0] pwm1_duty_upper_o,
  output logic [1:0] pwm2_duty_upper_o,
  output logic [1:0] pwm3_duty_upper_o,
  // Analog enables and trim
  output logic comparator_on_o,
  output logic res_freq_conv_on_o,
  output logic [7:0] rfc_pad_a_o,
  output logic [5:0] rfc_pad_b_o,
  output logic [10:0] osc_trim_value_o
);

  logic ext_ref_ff;
  logic [1:0] lvl_ff;
  logic [1:0] spw_ff;
  logic [1:0] res_ff;
  logic [2:0] pb_hi_ff;
  logic [7:0] wake_ff;
  logic [7:0] analog_pin_only_select_ff;
  logic [7:0] edge_ff;
  logic [7:0] timer_pwm_upper_bits_ff;
  logic [1:0] t3_ff;
  logic [1:0] pwm3_ff;
  logic cmp_ff;
  logic rfc_en_ff;
  logic [3:0] psel_ff;
  logic [10:0] trim_ff;
  logic trim_loaded_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] tload_ff;
  logic pb0_d_ff;
  logic pb1_d_ff;
  logic wr_hit;

  // Decode helper shared by all write processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // Edge detect shared by both external interrupts
  function automatic logic edge_fire(input logic [1:0] code,
                                     input logic cur, input logic old);
    case (code)
      mats_pkg::EDGE_RISING: edge_fire = cur & ~old;
      mats_pkg::EDGE_FALLING: edge_fire = ~cur & old;
      mats_pkg::EDGE_BOTH: edge_fire = cur ^ old;
      default: edge_fire = 1'b0; // Reserved code fires nothing [R21]
    endcase
  endfunction : edge_fire

  assign wr_hit = wr_i;

  // ADC reference register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_ref_ff <= mats_pkg::RST_EXT_REF_SELECT; // [R1]
      lvl_ff <= mats_pkg::RST_INT_REF_LEVEL; // [R2]
    end else if (wr_hit && hit(addr_i, mats_pkg::ADDR_ADC_HIGH_REFERENCE_CTRL))
    begin
      ext_ref_ff <= wdata_i[7]; // [R1]
      lvl_ff <= wdata_i[1:0]; // [R2]
    end
  end

  // Sample and resolution register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb_hi_ff <= 3'h0;
      spw_ff <= mats_pkg::RST_SAMPLE_PULSE_WIDTH; // [R3]
      res_ff <= mats_pkg::RST_CONVERSION_RESOLUTION; // [R4]
    end else if (wr_hit &&
                 hit(addr_i, mats_pkg::ADDR_ADC_SAMPLE_RESOLUTION_CTRL)) begin
      pb_hi_ff <= wdata_i[6:4]; // [R5]
      spw_ff <= wdata_i[3:2]; // [R3]
      res_ff <= wdata_i[1:0]; // [R4]
    end
  end

  // Wake, analog-only and edge registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_ff <= mats_pkg::RST_PORT_A_WAKE_ENABLE; // [R7]
      analog_pin_only_select_ff <= mats_pkg::RST_ANALOG_PIN_ONLY; // [R6]
      edge_ff <= mats_pkg::RST_EXT_INTERRUPT_EDGE; // [R9] [R10]
    end else if (wr_hit) begin
      if (hit(addr_i, mats_pkg::ADDR_PORT_A_WAKEUP_ENABLE)) begin
        wake_ff <= wdata_i; // [R7]
      end
      if (hit(addr_i, mats_pkg::ADDR_ANALOG_PIN_ONLY_SELECT)) begin
        analog_pin_only_select_ff <= wdata_i; // [R5] [R6]
      end
      if (hit(addr_i, mats_pkg::ADDR_EXT_INTERRUPT_EDGE_CTRL)) begin
        edge_ff <= wdata_i; // [R8] [R9] [R10]
      end
    end
  end

  // Timer and PWM upper bits; reload strobes pulse on a write
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_pwm_upper_bits_ff <= 8'h00;
      t3_ff <= 2'h0;
      pwm3_ff <= 2'h0;
      tload_ff <= 3'h0;
    end else begin
      tload_ff <= 3'h0;
      if (wr_hit && hit(addr_i, mats_pkg::ADDR_TIMER_PWM_UPPER_BITS)) begin
        timer_pwm_upper_bits_ff <= wdata_i; // [R11] [R12] [R14]
        tload_ff[1:0] <= 2'h3;
      end
      if (wr_hit && hit(addr_i, mats_pkg::ADDR_TIMER3_PWM3_UPPER_BITS)) begin
        t3_ff <= wdata_i[5:4]; // [R13]
        pwm3_ff <= wdata_i[1:0]; // [R15]
        tload_ff[2] <= 1'b1;
      end
    end
  end

  // Comparator and resistance-to-frequency controls
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_ff <= 1'b0; // [R16]
      rfc_en_ff <= 1'b0; // [R17]
      psel_ff <= 4'h0;
    end else if (wr_hit) begin
      if (hit(addr_i, mats_pkg::ADDR_ANALOG_CIRCUIT_ENABLE)) begin
        cmp_ff <= wdata_i[7]; // [R16]
      end
      if (hit(addr_i, mats_pkg::ADDR_RES_FREQ_CONV_CTRL)) begin
        rfc_en_ff <= wdata_i[7]; // [R17]
        psel_ff <= wdata_i[3:0]; // [R18]
      end
    end
  end

  // Trim: strap is taken on the first clock after reset release, since
  // an async reset may only load constants. Writes only in slow mode.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim_ff <= 11'h000;
      trim_loaded_ff <= 1'b0;
    end else if (!trim_loaded_ff) begin
      trim_ff <= {factory_trim_i, mats_pkg::RST_OSC_TRIM_LOW_NIBBLE}; // [R19]
      trim_loaded_ff <= 1'b1;
    end else if (wr_hit && slow_mode_i) begin // [R19]
      if (hit(addr_i, mats_pkg::ADDR_OSC_TRIM_HIGH)) begin
        trim_ff[10:8] <= wdata_i[2:0];
      end
      if (hit(addr_i, mats_pkg::ADDR_OSC_TRIM_LOW)) begin
        trim_ff[7:0] <= wdata_i;
      end
    end
  end

  // Read mux; timer upper bits read the live counters
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_i)
      mats_pkg::ADDR_ADC_HIGH_REFERENCE_CTRL:
        nxt_rdata = {ext_ref_ff, 5'h00, lvl_ff};
      mats_pkg::ADDR_ADC_SAMPLE_RESOLUTION_CTRL:
        nxt_rdata = {1'b0, pb_hi_ff, spw_ff, res_ff};
      mats_pkg::ADDR_PORT_A_WAKEUP_ENABLE: nxt_rdata = wake_ff;
      mats_pkg::ADDR_ANALOG_PIN_ONLY_SELECT: nxt_rdata = analog_pin_only_select_ff;
      mats_pkg::ADDR_EXT_INTERRUPT_EDGE_CTRL: nxt_rdata = edge_ff;
      mats_pkg::ADDR_TIMER_PWM_UPPER_BITS:
        nxt_rdata = {timer2_count_i[9:8], timer1_count_i[9:8],
                     timer_pwm_upper_bits_ff[3:0]}; // [R11] [R12]
      mats_pkg::ADDR_ANALOG_CIRCUIT_ENABLE: nxt_rdata = {cmp_ff, 7'h00};
      mats_pkg::ADDR_RES_FREQ_CONV_CTRL:
        nxt_rdata = {rfc_en_ff, 3'h0, psel_ff};
      mats_pkg::ADDR_TIMER3_PWM3_UPPER_BITS:
        nxt_rdata = {2'h0, timer3_count_i[9:8], 2'h0, pwm3_ff}; // [R13]
      mats_pkg::ADDR_OSC_TRIM_HIGH: nxt_rdata = {5'h00, trim_ff[10:8]};
      mats_pkg::ADDR_OSC_TRIM_LOW: nxt_rdata = trim_ff[7:0];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data register, valid the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ADC clock enable; restarted by a sample start for whole-clock pulses
  logic [4:0] div_ff;
  logic [4:0] div_sel;
  logic adc_tick;
  mats_pkg::mats_smp_t smp_ff;
  always_comb begin
    case (adc_clock_divider_i)
      2'h0: div_sel = mats_pkg::DIV_CODE0;
      2'h1: div_sel = mats_pkg::DIV_CODE1;
      2'h2: div_sel = mats_pkg::DIV_CODE2;
      default: div_sel = mats_pkg::DIV_CODE3;
    endcase
  end
  assign adc_tick = (div_ff >= div_sel - 5'h01); // [R20]
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= 5'h00;
    end else if (adc_tick ||
                 (sample_start_i && smp_ff == mats_pkg::MATS_SMP_IDLE)) begin
      div_ff <= 5'h00; // [R20]
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end

  // Sampling pulse FSM: high for 2^code ADC clock ticks
  logic [3:0] smp_cnt_ff;
  logic [3:0] smp_len;
  assign smp_len = 4'h1 << spw_ff; // [R3]
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smp_ff <= mats_pkg::MATS_SMP_IDLE;
      smp_cnt_ff <= 4'h0;
    end else begin
      case (smp_ff)
        mats_pkg::MATS_SMP_IDLE: begin
          smp_cnt_ff <= 4'h0;
          if (sample_start_i) begin
            smp_ff <= mats_pkg::MATS_SMP_RUN;
          end
        end
        mats_pkg::MATS_SMP_RUN: begin
          if (adc_tick) begin // [R20]
            smp_cnt_ff <= smp_cnt_ff + 4'h1;
            if (smp_cnt_ff + 4'h1 == smp_len) begin // [R3]
              smp_ff <= mats_pkg::MATS_SMP_DONE;
            end
          end
        end
        mats_pkg::MATS_SMP_DONE: smp_ff <= mats_pkg::MATS_SMP_IDLE;
        default: smp_ff <= mats_pkg::MATS_SMP_IDLE;
      endcase
    end
  end
  assign sample_pulse_o = (smp_ff == mats_pkg::MATS_SMP_RUN);

  // External interrupt edge detection, only when the pin is routed
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb0_d_ff <= 1'b0;
      pb1_d_ff <= 1'b0;
      ext_irq0_trig_o <= 1'b0;
      ext_irq1_trig_o <= 1'b0;
    end else begin
      pb0_d_ff <= pb0_i;
      pb1_d_ff <= pb1_i;
      ext_irq0_trig_o <= edge_ff[4] &
                         edge_fire(edge_ff[1:0], pb0_i, pb0_d_ff); // [R8] [R9]
      ext_irq1_trig_o <= edge_ff[5] &
                         edge_fire(edge_ff[3:2], pb1_i, pb1_d_ff); // [R8] [R9]
    end
  end

  // Field outputs
  assign rdata_o = rdata_ff;
  assign ext_ref_select_o = ext_ref_ff; // [R1]
  assign int_ref_level_o = lvl_ff; // [R2]
  assign conversion_resolution_o = res_ff;
  assign res12_o = res_ff[1]; // Upper bit alone selects 12 bits [R4]
  assign port_a_analog_only_o = analog_pin_only_select_ff[4:0]; // [R6]
  assign port_b_analog_only_o = {pb_hi_ff, analog_pin_only_select_ff[7:5]}; // [R5]
  assign port_a_wake_enable_o = wake_ff; // [R7]
  assign ext_irq0_pin_select_o = edge_ff[4];
  assign ext_irq1_pin_select_o = edge_ff[5];
  assign ext_irq0_edge_o = edge_ff[1:0];
  assign ext_irq1_edge_o = edge_ff[3:2];
  assign timer2_upper_bits_o = timer_pwm_upper_bits_ff[7:6];
  assign timer1_upper_bits_o = timer_pwm_upper_bits_ff[5:4];
  assign timer3_upper_bits_o = t3_ff;
  assign timer1_upper_load_o = tload_ff[0];
  assign timer2_upper_load_o = tload_ff[1];
  assign timer3_upper_load_o = tload_ff[2];
  assign pwm2_duty_upper_o = timer_pwm_upper_bits_ff[3:2]; // [R14]
  assign pwm1_duty_upper_o = timer_pwm_upper_bits_ff[1:0]; // [R14]
  assign pwm3_duty_upper_o = pwm3_ff; // [R15]
  assign comparator_on_o = cmp_ff;
  assign res_freq_conv_on_o = rfc_en_ff;
  // One-hot pad select; codes above the last pad select nothing [R18]
  assign rfc_pad_a_o = (rfc_en_ff && !psel_ff[3]) ?
                       (8'h01 << psel_ff[2:0]) : 8'h00;
  assign rfc_pad_b_o = (rfc_en_ff && psel_ff[3] &&
                        psel_ff <= mats_pkg::PAD_LAST_CODE) ?
                       (6'h01 << (psel_ff - mats_pkg::PAD_PORT_B_BASE)) :
                       6'h00;
  assign osc_trim_value_o = trim_ff;

  // Checks
  a_ref_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == mats_pkg::ADDR_ADC_HIGH_REFERENCE_CTRL
    |=> ext_ref_select_o == $past(wdata_i[7])) else $error("ref bit"); // [R1]
  a_level_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == mats_pkg::ADDR_ADC_HIGH_REFERENCE_CTRL
    |=> int_ref_level_o == $past(wdata_i[1:0])) else $error("level"); // [R2]
  a_res_twelve: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == mats_pkg::ADDR_ADC_SAMPLE_RESOLUTION_CTRL
    |=> res12_o == $past(wdata_i[1])) else $error("res12"); // [R4]
  a_wake_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == mats_pkg::ADDR_PORT_A_WAKEUP_ENABLE
    |=> port_a_wake_enable_o == $past(wdata_i)) else $error("wake"); // [R7]
  a_reserved_edge: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    $past(edge_ff[1:0]) == mats_pkg::EDGE_RESERVED |-> !ext_irq0_trig_o)
    else $error("reserved edge fired"); // [R21]
  a_timer_live: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_i && addr_i == mats_pkg::ADDR_TIMER_PWM_UPPER_BITS
    |=> rdata_o[7:4] == $past({timer2_count_i[9:8], timer1_count_i[9:8]}))
    else $error("live read"); // [R11]
  a_trim_locked: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    trim_loaded_ff && !slow_mode_i |=> $stable(osc_trim_value_o))
    else $error("trim changed"); // [R19]
  a_pad_onehot: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    res_freq_conv_on_o && psel_ff <= mats_pkg::PAD_LAST_CODE
    |-> $onehot({rfc_pad_b_o, rfc_pad_a_o})) else $error("pad"); // [R18]

endmodule : mats_regs

// ===== mats_tb.sv
// Self-checking bench for the analog, timer and trim register bank.
// Assumes the bank stands alone; the bench drives every port itself.
`timescale 1ns/1ps
module tb;
  // Design inputs, all given a value at time zero
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [6:0] factory_trim_i = 7'h00;
  logic slow_mode_i = 1'b0;
  logic [9:0] timer1_count_i = 10'h000;
  logic [9:0] timer2_count_i = 10'h000;
  logic [9:0] timer3_count_i = 10'h000;
  logic sample_start_i = 1'b0;
  logic [1:0] adc_clock_divider_i = 2'h0;
  logic pb0_i = 1'b0;
  logic pb1_i = 1'b0;
  // Design outputs
  logic [7:0] rdata_o, port_a_wake_enable_o, rfc_pad_a_o;
  logic [1:0] int_ref_level_o, conversion_resolution_o, ext_irq0_edge_o;
  logic [1:0] ext_irq1_edge_o, timer1_upper_bits_o, timer2_upper_bits_o;
  logic [1:0] timer3_upper_bits_o, pwm1_duty_upper_o, pwm2_duty_upper_o;
  logic [1:0] pwm3_duty_upper_o;
  logic [4:0] port_a_analog_only_o;
  logic [5:0] port_b_analog_only_o, rfc_pad_b_o;
  logic [10:0] osc_trim_value_o;
  logic sample_pulse_o, ext_irq0_trig_o, ext_irq1_trig_o, ext_ref_select_o;
  logic res12_o, ext_irq0_pin_select_o, ext_irq1_pin_select_o;
  logic timer1_upper_load_o, timer2_upper_load_o, timer3_upper_load_o;
  logic comparator_on_o, res_freq_conv_on_o;
  // Bench bookkeeping
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n_trig0 = 0, n_trig1 = 0, n_hi = 0, n_ld1 = 0, n_ld2 = 0, n_ld3 = 0;
  integer seed = 37264;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] v [7];
  logic [7:0] ra [7] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h1A, 8'h1B};
  logic [7:0] rm [7] = '{8'h83, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h80, 8'h8F};
  int div [4] = '{16, 8, 1, 2};

  mats_regs uut (
    .sys_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .factory_trim_i, .slow_mode_i, .timer1_count_i, .timer2_count_i,
    .timer3_count_i, .sample_start_i, .adc_clock_divider_i, .sample_pulse_o,
    .pb0_i, .pb1_i, .ext_irq0_trig_o, .ext_irq1_trig_o, .ext_ref_select_o,
    .int_ref_level_o, .conversion_resolution_o, .res12_o,
    .port_a_analog_only_o, .port_b_analog_only_o, .port_a_wake_enable_o,
    .ext_irq0_pin_select_o, .ext_irq1_pin_select_o, .ext_irq0_edge_o,
    .ext_irq1_edge_o, .timer1_upper_bits_o, .timer2_upper_bits_o,
    .timer3_upper_bits_o, .timer1_upper_load_o, .timer2_upper_load_o,
    .timer3_upper_load_o, .pwm1_duty_upper_o, .pwm2_duty_upper_o,
    .pwm3_duty_upper_o, .comparator_on_o, .res_freq_conv_on_o,
    .rfc_pad_a_o, .rfc_pad_b_o, .osc_trim_value_o
  );

  // 250 MHz core clock
  always #2 sys_clk_i = ~sys_clk_i;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus cycle; strobes stay one cycle since every call sets them again
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  // The expected byte is noted before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, addr_i, 8'h00);
  endtask : idle

  // Watcher: read data only in the cycle after the strobe, else zero;
  // also counts output pulses and cuts a hang short
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
    if (rd_seen) begin
      chk(rdata_o, exp_q.pop_front());
    end else if (reset_n_i === 1'b1 && rdata_o !== 8'h00) begin
      chk(rdata_o, 8'h00);
    end
    rd_seen <= rd_i;
    if (ext_irq0_trig_o === 1'b1) n_trig0++;
    if (ext_irq1_trig_o === 1'b1) n_trig1++;
    if (sample_pulse_o === 1'b1) n_hi++;
    if (timer1_upper_load_o === 1'b1) n_ld1++;
    if (timer2_upper_load_o === 1'b1) n_ld2++;
    if (timer3_upper_load_o === 1'b1) n_ld3++;
  end

  // Main sequence
  initial begin
    logic [7:0] t19, t1c;
    int b0, b1, bh;
    factory_trim_i <= 7'($random(seed));
    timer1_count_i <= 10'($random(seed));
    timer2_count_i <= 10'($random(seed));
    timer3_count_i <= 10'($random(seed));
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    idle(2);
    // Reset view at the field outputs
    chk(ext_ref_select_o, 16'h0000);
    chk(int_ref_level_o, 16'h0003);
    chk(conversion_resolution_o, 16'h0002);
    chk(port_a_analog_only_o, 16'h0000);
    chk(port_a_wake_enable_o, 16'h00FF);
    chk({ext_irq1_edge_o, ext_irq0_edge_o}, 16'h0005);
    chk(osc_trim_value_o, {5'h00, factory_trim_i, 4'h8});
    // Reset view through the register port, unmapped place included
    rd(8'h13, 8'h03);
    rd(8'h14, 8'h0A);
    rd(8'h15, 8'hFF);
    rd(8'h16, 8'h00);
    rd(8'h18, 8'h05);
    rd(8'h19, {timer2_count_i[9:8], timer1_count_i[9:8], 4'h0});
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h00);
    rd(8'h1C, {2'h0, timer3_count_i[9:8], 4'h0});
    rd(8'h1D, {5'h00, factory_trim_i[6:4]});
    rd(8'h1E, {factory_trim_i[3:0], 4'h8});
    rd(8'h17, 8'h00);
    // Random writes back to back, read back, then the field outputs
    for (int i = 0; i < 4; i++) begin
      timer1_count_i <= 10'($random(seed));
      timer2_count_i <= 10'($random(seed));
      timer3_count_i <= 10'($random(seed));
      t19 = 8'($random(seed));
      t1c = 8'($random(seed));
      for (int k = 0; k < 7; k++) begin
        v[k] = 8'($random(seed));
        wr(ra[k], v[k]);
      end
      wr(8'h19, t19);
      wr(8'h1C, t1c);
      wr(8'h17, 8'($random(seed)));
      for (int k = 0; k < 7; k++) rd(ra[k], v[k] & rm[k]);
      rd(8'h19, {timer2_count_i[9:8], timer1_count_i[9:8], t19[3:0]});
      rd(8'h1C, {2'h0, timer3_count_i[9:8], 2'h0, t1c[1:0]});
      rd(8'h17, 8'h00);
      idle(2);
      chk({ext_ref_select_o, int_ref_level_o}, {v[0][7], v[0][1:0]});
      chk({res12_o, conversion_resolution_o}, {v[1][1], v[1][1:0]});
      chk(port_b_analog_only_o, {v[1][6:4], v[3][7:5]});
      chk(port_a_analog_only_o, v[3][4:0]);
      chk(port_a_wake_enable_o, v[2]);
      chk({ext_irq1_pin_select_o, ext_irq0_pin_select_o}, v[4][5:4]);
      chk({ext_irq1_edge_o, ext_irq0_edge_o}, v[4][3:0]);
      chk({timer2_upper_bits_o, timer1_upper_bits_o}, t19[7:4]);
      chk(timer3_upper_bits_o, t1c[5:4]);
      chk({pwm2_duty_upper_o, pwm1_duty_upper_o}, t19[3:0]);
      chk(pwm3_duty_upper_o, t1c[1:0]);
      chk({comparator_on_o, res_freq_conv_on_o}, {v[5][7], v[6][7]});
      chk(16'(n_ld1), 16'(i + 1));
      chk(16'(n_ld2), 16'(i + 1));
      chk(16'(n_ld3), 16'(i + 1));
    end
    // Every edge code; the last pass has both pins routed away
    for (int c = 0; c < 5; c++) begin
      wr(8'h18, c < 4 ? {4'h3, 2'(c), 2'(c)} : 8'h0F);
      idle(2);
      b0 = n_trig0;
      b1 = n_trig1;
      pb0_i <= 1'b1;
      pb1_i <= 1'b1;
      idle(4);
      chk(16'(n_trig0 - b0), 16'(c == 1 || c == 3));
      chk(16'(n_trig1 - b1), 16'(c == 1 || c == 3));
      b0 = n_trig0;
      b1 = n_trig1;
      pb0_i <= 1'b0;
      pb1_i <= 1'b0;
      idle(4);
      chk(16'(n_trig0 - b0), 16'(c == 2 || c == 3));
      chk(16'(n_trig1 - b1), 16'(c == 2 || c == 3));
    end
    // Every pad code with the function on, then one with it off
    for (int c = 0; c < 16; c++) begin
      wr(8'h1B, {4'h8, 4'(c)});
      idle(2);
      chk(rfc_pad_a_o, c < 8 ? 16'(1 << c) : 16'h0000);
      chk(rfc_pad_b_o, (c > 7 && c < 14) ? 16'(1 << (c - 8)) : 16'h0);
    end
    wr(8'h1B, 8'h03);
    idle(2);
    chk({res_freq_conv_on_o, rfc_pad_a_o}, 16'h0000);
    // Trim writes count only in slow mode
    wr(8'h1D, 8'h05);
    wr(8'h1E, 8'h5A);
    rd(8'h1D, {5'h00, factory_trim_i[6:4]});
    rd(8'h1E, {factory_trim_i[3:0], 4'h8});
    slow_mode_i <= 1'b1;
    wr(8'h1D, 8'hFD);
    wr(8'h1E, 8'hA5);
    rd(8'h1D, 8'h05);
    idle(2);
    chk(osc_trim_value_o, 16'h05A5);
    slow_mode_i <= 1'b0;
    // Sampling pulse length for every divider and width code
    for (int d = 0; d < 4; d++) begin
      for (int w = 0; w < 4; w++) begin
        adc_clock_divider_i <= 2'(d);
        wr(8'h14, {4'h0, 2'(w), 2'h0});
        idle(2);
        bh = n_hi;
        sample_start_i <= 1'b1;
        idle(1);
        sample_start_i <= 1'b0;
        for (int t = 0; t < 300; t++) begin
          @(negedge sys_clk_i);
          if (n_hi > bh && sample_pulse_o === 1'b0) break;
        end
        chk(16'(n_hi - bh), 16'((1 << w) * div[d]));
      end
    end
    // A second reset in mid-run restores the defaults
    reset_n_i <= 1'b0;
    idle(2);
    reset_n_i <= 1'b1;
    idle(2);
    chk({port_a_wake_enable_o, ext_irq0_edge_o}, 16'h03FD);
    report_and_stop();
  end
endmodule : tb
